// [logic/pcs_4b5b_coder.sv]
// What this block does
// - Nibbles coded to five-bit groups, and back
// - Carrier sense is transmitting or receiving
// - Collision when receiving during transmission
// - Transmit keeps a transmitting flag
// - Receive drives data, valid, error, receiving
// - Transmit sends uninterrupted code-groups from MAC
// - Receive accepts one code-bit per bit slot
// - Both directions drop activity on link failure
// - Alignment found only by the start delimiter
// - Data decoded only after start delimiter seen
// - Any data group order, carried uninterpreted
// - Legacy S and Q never sent, invalid
// - R only ends a stream
// - H carries transmit errors
// - Four data bits per five code-bits
// - MII stays one nibble wide, synchronous
// - Idle 11111 fills between streams
// - J K replace two preamble nibbles, one restored on receive
// - Streams end T R, errors send H
`timescale 1ns/100ps
`include "pcs_4b5b_defines.svh"
module pcs_4b5b_coder #(
  parameter int BIT_DIV = `BIT_RATE_DIV
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Medium side
  input  wire logic       linkUp,
  input  wire logic       rxCodeBit,
  output logic            txCodeBit,
  output logic            codeBitStrobe,
  // MII transmit
  input  wire logic [3:0] txData,
  input  wire logic       txEnable,
  input  wire logic       txError,
  output logic            nibbleStrobe,
  // MII receive and status
  output logic      [3:0] rxData,
  output logic            rxValid,
  output logic            rxError,
  output logic            carrierSense,
  output logic            collision
);

  // Divider counter is eight bits wide; zero would wrap to a 256-clock slot
  if (BIT_DIV < 1 || BIT_DIV > 255) begin : g_bad_div
    $error("BIT_DIV out of range");
  end

  typedef struct packed {
    logic [7:0]            divCnt;
    logic [2:0]            bitCnt;
    logic [4:0]            txShift;
    pcs_4b5b_pkg::txState_t txState;
    logic [9:0]            rxWin;
    logic [2:0]            rxCnt;
    pcs_4b5b_pkg::rxState_t rxState;
    logic [3:0]            rxData;
    logic                  rxValid;
    logic                  rxError;
    logic                  transmitting;
    logic                  receiving;
    logic                  txBit;
    logic                  collision;
  } state_t;

  state_t stReg;
  state_t stNext;

  // Line idles high out of reset so the far end sees fill, not a delimiter
  localparam state_t RESET_ST = '{
    divCnt:       8'h00,
    bitCnt:       3'h0,
    txShift:      `CG_IDLE,
    txState:      pcs_4b5b_pkg::TX_IDLE,
    rxWin:        10'h000,
    rxCnt:        3'h0,
    rxState:      pcs_4b5b_pkg::RX_IDLE,
    rxData:       4'h0,
    rxValid:      1'b0,
    rxError:      1'b0,
    transmitting: 1'b0,
    receiving:    1'b0,
    txBit:        1'b1,
    collision:    1'b0
  };

  // Group boundary reached once five fresh bits are in the window
  function automatic logic groupDone(input logic [2:0] cnt);
    return cnt == 3'(`CODE_BITS);
  endfunction

  // Start pair is the only pattern trusted without alignment
  function automatic logic isStartPair(input logic [9:0] win);
    return win == {`CG_J, `CG_K};
  endfunction

  logic [4:0] encGroup;
  logic [3:0] decNibble;
  logic       decIsData;
  logic [4:0] rxGroup;

  // Aligned group: the five newest bits of the window after a fresh bit
  assign rxGroup = stNext.rxWin[4:0];

  code_group_codec u_codec (
    .encNibble (txData),
    .encGroup  (encGroup),
    .decGroup  (rxGroup),
    .decNibble (decNibble),
    .decIsData (decIsData)
  );

  logic bitTick;
  logic groupTick;
  assign bitTick   = (stReg.divCnt == 8'(BIT_DIV - 1));
  assign groupTick = bitTick && (stReg.bitCnt == 3'(`CODE_BITS - 1));

  always_comb begin
    stNext = stReg;
    if (bitTick) begin
      stNext.divCnt = 8'h00;
      if (groupTick) begin
        stNext.bitCnt = 3'h0;
      end else begin
        stNext.bitCnt = stReg.bitCnt + 3'h1;
      end
    end else begin
      stNext.divCnt = stReg.divCnt + 8'h01;
    end

    // Transmit: one group per five bit slots, never a gap
    if (bitTick) begin
      stNext.txBit = stReg.txShift[4];
      stNext.txShift = {stReg.txShift[3:0], 1'b0};
    end
    if (groupTick) begin
      case (stReg.txState)
        pcs_4b5b_pkg::TX_IDLE: begin
          if (txEnable && linkUp) begin
            stNext.txShift = `CG_J;
            stNext.txState = pcs_4b5b_pkg::TX_K;
          end else begin
            stNext.txShift = `CG_IDLE;
          end
        end
        pcs_4b5b_pkg::TX_K: begin
          if (!linkUp) begin
            stNext.txShift = `CG_IDLE;
            stNext.txState = pcs_4b5b_pkg::TX_IDLE;
          end else begin
            stNext.txShift = `CG_K;
            stNext.txState = pcs_4b5b_pkg::TX_DATA;
          end
        end
        pcs_4b5b_pkg::TX_DATA: begin
          if (!linkUp) begin
            stNext.txShift = `CG_IDLE;
            stNext.txState = pcs_4b5b_pkg::TX_IDLE;
          end else if (!txEnable) begin
            stNext.txShift = `CG_T;
            stNext.txState = pcs_4b5b_pkg::TX_R;
          end else if (txError) begin
            stNext.txShift = `CG_H;
          end else begin
            stNext.txShift = encGroup;
          end
        end
        pcs_4b5b_pkg::TX_R: begin
          stNext.txShift = `CG_R;
          stNext.txState = pcs_4b5b_pkg::TX_IDLE;
        end
        default: begin
          stNext.txShift = `CG_IDLE;
          stNext.txState = pcs_4b5b_pkg::TX_IDLE;
        end
      endcase
    end
    stNext.transmitting = (stReg.txState != pcs_4b5b_pkg::TX_IDLE);

    // Receive side runs on the same bit slots as transmit
    // Receive: one bit taken per slot, MSB first
    if (bitTick) begin
      stNext.rxWin = {stReg.rxWin[8:0], rxCodeBit};
      stNext.rxCnt = stReg.rxCnt + 3'h1;
    end
    stNext.rxError = 1'b0;
    if (bitTick) begin
      case (stReg.rxState)
        pcs_4b5b_pkg::RX_IDLE: begin
          stNext.rxValid = 1'b0;
          // Only J K can set alignment, seen at any bit offset
          if (linkUp && isStartPair(stNext.rxWin)) begin
            stNext.rxState = pcs_4b5b_pkg::RX_DATA;
            stNext.rxCnt = 3'h0;
            stNext.rxData = `PREAMBLE_NIB;
            stNext.rxValid = 1'b1;
            stNext.receiving = 1'b1;
          end
        end
        pcs_4b5b_pkg::RX_DATA: begin
          if (!linkUp) begin
            stNext.rxState = pcs_4b5b_pkg::RX_IDLE;
            stNext.rxValid = 1'b0;
            stNext.receiving = 1'b0;
          end else if (groupDone(stNext.rxCnt)) begin
            stNext.rxCnt = 3'h0;
            if (decIsData) begin
              stNext.rxData = decNibble;
            end else if (rxGroup == `CG_T) begin
              stNext.rxState = pcs_4b5b_pkg::RX_R;
              stNext.rxValid = 1'b0;
            end else if (rxGroup == `CG_IDLE) begin
              // Premature end; flag it
              stNext.rxState = pcs_4b5b_pkg::RX_IDLE;
              stNext.rxError = 1'b1;
              stNext.rxValid = 1'b0;
              stNext.receiving = 1'b0;
            end else begin
              stNext.rxError = 1'b1;
            end
          end
        end
        pcs_4b5b_pkg::RX_R: begin
          if (!linkUp) begin
            stNext.rxState = pcs_4b5b_pkg::RX_IDLE;
            stNext.receiving = 1'b0;
          end else if (groupDone(stNext.rxCnt)) begin
            // R closes the stream; anything else is an error
            stNext.rxError = (rxGroup != `CG_R);
            stNext.rxState = pcs_4b5b_pkg::RX_IDLE;
            stNext.receiving = 1'b0;
          end
        end
        default: begin
          stNext.rxState = pcs_4b5b_pkg::RX_IDLE;
          stNext.receiving = 1'b0;
        end
      endcase
    end else begin
      stNext.rxError = stReg.rxError;
    end

    // Held in RX_DATA to the next group boundary, five bit slots, so it is seen on a nibble boundary
    if (bitTick && stReg.rxState == pcs_4b5b_pkg::RX_DATA && stNext.rxCnt != 3'h0) begin
      stNext.rxError = stReg.rxError;
    end

    // Registered so it lines up with carrier sense
    stNext.collision = stNext.transmitting && stNext.receiving;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stReg <= RESET_ST;
    end else begin
      stReg <= stNext;
    end
  end

  // MII nibble path stays 4 bits and clock-synchronous
  assign rxData        = stReg.rxData;
  assign rxValid       = stReg.rxValid;
  assign rxError       = stReg.rxError;
  assign txCodeBit     = stReg.txBit;
  assign codeBitStrobe = bitTick;
  assign nibbleStrobe  = groupTick;
  assign carrierSense  = stReg.transmitting || stReg.receiving;
  assign collision     = stReg.collision;

endmodule

// [logic/pcs_4b5b_defines.svh]
`ifndef PCS_4B5B_DEFINES_SVH
`define PCS_4B5B_DEFINES_SVH

`define CG_IDLE      5'h1f
`define CG_J         5'h18
`define CG_K         5'h11
`define CG_T         5'h0d
`define CG_R         5'h07
`define CG_H         5'h04
`define PREAMBLE_NIB 4'h5
`define CODE_BITS    5
`define BIT_RATE_DIV 2

`endif

// [logic/pcs_4b5b_pkg.sv]
package pcs_4b5b_pkg;
  typedef enum {TX_IDLE, TX_J, TX_K, TX_DATA, TX_T, TX_R} txState_t;
  typedef enum {RX_IDLE, RX_K, RX_DATA, RX_R} rxState_t;
endpackage

// [logic/code_group_codec.sv]
`timescale 1ns/100ps
`include "pcs_4b5b_defines.svh"
// Pure 4B/5B table lookup, both directions
module code_group_codec (
  // Encode
  input  wire logic [3:0] encNibble,
  output logic      [4:0] encGroup,
  // Decode
  input  wire logic [4:0] decGroup,
  output logic      [3:0] decNibble,
  output logic            decIsData
);

  always_comb begin
    case (encNibble)
      4'h0: encGroup = 5'h1e;
      4'h1: encGroup = 5'h09;
      4'h2: encGroup = 5'h14;
      4'h3: encGroup = 5'h15;
      4'h4: encGroup = 5'h0a;
      4'h5: encGroup = 5'h0b;
      4'h6: encGroup = 5'h0e;
      4'h7: encGroup = 5'h0f;
      4'h8: encGroup = 5'h12;
      4'h9: encGroup = 5'h13;
      4'ha: encGroup = 5'h16;
      4'hb: encGroup = 5'h17;
      4'hc: encGroup = 5'h1a;
      4'hd: encGroup = 5'h1b;
      4'he: encGroup = 5'h1c;
      default: encGroup = 5'h1d;
    endcase
  end

  always_comb begin
    decIsData = 1'b1;
    case (decGroup)
      5'h1e: decNibble = 4'h0;
      5'h09: decNibble = 4'h1;
      5'h14: decNibble = 4'h2;
      5'h15: decNibble = 4'h3;
      5'h0a: decNibble = 4'h4;
      5'h0b: decNibble = 4'h5;
      5'h0e: decNibble = 4'h6;
      5'h0f: decNibble = 4'h7;
      5'h12: decNibble = 4'h8;
      5'h13: decNibble = 4'h9;
      5'h16: decNibble = 4'ha;
      5'h17: decNibble = 4'hb;
      5'h1a: decNibble = 4'hc;
      5'h1b: decNibble = 4'hd;
      5'h1c: decNibble = 4'he;
      5'h1d: decNibble = 4'hf;
      default: begin
        decNibble = 4'h0;
        decIsData = 1'b0;
      end
    endcase
  end

endmodule

// [sim/pcs_4b5b_coder_checker.sv]
`timescale 1ns/100ps
module pcs_4b5b_coder_checker #(
  parameter int BIT_DIV = 2
) (
  // Watched ports
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic       linkUp,
  input wire logic       txCodeBit,
  input wire logic       codeBitStrobe,
  input wire logic       nibbleStrobe,
  input wire logic [3:0] rxData,
  input wire logic       rxValid,
  input wire logic       carrierSense,
  input wire logic       collision
);
  logic [7:0] clkCnt;
  logic [2:0] slotCnt;
  logic       seen;
  // Spacing checked only once a full nibble has passed since reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clkCnt  <= 8'h00;
      slotCnt <= 3'h0;
      seen    <= 1'b0;
    end else begin
      clkCnt  <= codeBitStrobe ? 8'h00 : clkCnt + 8'h01;
      slotCnt <= nibbleStrobe ? 3'h0 : slotCnt + 3'(codeBitStrobe);
      seen    <= seen | nibbleStrobe;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence linkGone;
    !linkUp [*3];
  endsequence
  sequence streamOpen;
    $rose(rxValid);
  endsequence
  a_bit_spacing: assert property (codeBitStrobe && seen |-> clkCnt == 8'(BIT_DIV - 1))
    else $error("bit strobe spacing");
  a_nibble_slots: assert property (nibbleStrobe && seen |-> slotCnt == 3'h4)
    else $error("nibble strobe spacing");
  a_nibble_on_bit: assert property (nibbleStrobe |-> codeBitStrobe)
    else $error("nibble strobe off slot");
  a_link_quiet: assert property (linkGone |-> !carrierSense)
    else $error("carrier while link down");
  a_link_idle: assert property (!linkUp [*8] |-> txCodeBit)
    else $error("line not idle while link down");
  a_col_carrier: assert property (collision |-> carrierSense || $past(carrierSense))
    else $error("collision without carrier");
  a_valid_carrier: assert property (rxValid |-> carrierSense || $past(carrierSense))
    else $error("valid without carrier");
  a_valid_preamble: assert property (streamOpen |-> rxData == 4'h5)
    else $error("stream opens without preamble");
endmodule

bind pcs_4b5b_coder pcs_4b5b_coder_checker #(.BIT_DIV(BIT_DIV)) chk_i (
  .sys_clk(sys_clk), .rst_b(rst_b), .linkUp(linkUp), .txCodeBit(txCodeBit),
  .codeBitStrobe(codeBitStrobe), .nibbleStrobe(nibbleStrobe), .rxData(rxData),
  .rxValid(rxValid), .carrierSense(carrierSense), .collision(collision));

// [sim/mac_partner.sv]
`timescale 1ns/100ps
module mac_partner (
  // Clock and control from bench, nibble strobe from the coder
  input wire logic        sys_clk,
  input wire logic        nibbleStrobe,
  input wire logic        go,
  input wire logic [63:0] payload,
  input wire logic [4:0]  errAt,
  // MII transmit
  output logic      [3:0] txData,
  output logic            txEnable,
  output logic            txError
);
  logic stbSeen = 1'b0;
  int   idx = -1;
  initial txData = 4'h0;
  initial txEnable = 1'b0;
  initial txError = 1'b0;
  // Strobe copied mid-cycle so stepping never races the design edge
  always @(negedge sys_clk) stbSeen <= nibbleStrobe;
  always @(posedge sys_clk) begin
    if (stbSeen) begin
      #1;
      idx = (idx >= 0 || go) ? idx + 1 : -1;
      if (idx > 17) idx = -1;
      txEnable = idx >= 0;
      txData = idx < 2 ? 4'h5 : payload[(idx - 2) * 4 +: 4];
      txError = idx == errAt + 2;
    end
  end
endmodule

// [sim/tb.sv]
`timescale 1ns/100ps
`include "pcs_4b5b_defines.svh"
module tb;
  localparam logic [4:0] ENC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                                      5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  localparam logic [4:0] BAD [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0c,
                                      5'h10, 5'h04};
  logic        sys_clk = 1'b0, rst_b = 1'b0, linkUp = 1'b1, rxCodeBit = 1'b1, go = 1'b0;
  logic [63:0] payload = 64'h0;
  logic [4:0]  errAt = 5'h1f;
  logic [3:0]  txData, rxData;
  logic        txEnable, txError, txCodeBit, codeBitStrobe, nibbleStrobe;
  logic        rxValid, rxError, carrierSense, collision, errSeen, colSeen, valSeen;
  logic [9:0]  sh = 10'h3ff;
  logic [4:0]  txQ [$];
  logic [3:0]  rxExp [$], got [$];
  logic        aligned = 1'b0;
  int          error_cnt = 0, n_checks = 0, cyc = 0, bc = 0, rc = 0, r;
  pcs_4b5b_coder #(.BIT_DIV(2)) pcs_4b5b_coder_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .linkUp(linkUp), .rxCodeBit(rxCodeBit), .txCodeBit(txCodeBit),
    .codeBitStrobe(codeBitStrobe), .txData(txData), .txEnable(txEnable), .txError(txError),
    .nibbleStrobe(nibbleStrobe), .rxData(rxData), .rxValid(rxValid), .rxError(rxError),
    .carrierSense(carrierSense), .collision(collision));
  mac_partner mac_partner_i (.sys_clk(sys_clk), .nibbleStrobe(nibbleStrobe), .go(go),
    .payload(payload), .errAt(errAt), .txData(txData), .txEnable(txEnable), .txError(txError));
  always #2 sys_clk = ~sys_clk;
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  // Line and receive side sampled mid-cycle, clear of the update edge
  always @(negedge sys_clk) begin
    if (codeBitStrobe) begin
      sh = {sh[8:0], txCodeBit};
      bc++;
      if (aligned && bc == 5) begin
        check("txGroup", sh[4:0], txQ.pop_front());
        bc = 0;
        aligned = txQ.size() != 0;
      end
      if (!aligned && sh == {`CG_J, `CG_K}) begin
        check("txStart", txQ.size() != 0, 1);
        aligned = 1'b1;
        bc = 0;
      end
      if (rxValid) rc++;
      if (rxValid && rc % 5 == 2) got.push_back(rxData);
    end
    if (!rxValid) rc = 0;
    errSeen |= rxError;
    colSeen |= collision;
    valSeen |= rxValid;
  end
  task automatic sendBit(input logic b);
    @(negedge sys_clk iff codeBitStrobe);
    @(posedge sys_clk);
    #1 rxCodeBit = b;
  endtask
  task automatic sendGroup(input logic [4:0] g);
    for (int i = 4; i >= 0; i--) sendBit(g[i]);
  endtask
  task automatic rxFrame(input int n, input int badPos, input logic [4:0] badCg);
    logic [3:0] d;
    got.delete();
    errSeen = 1'b0;
    colSeen = 1'b0;
    repeat ($urandom_range(4)) sendBit(1'b1);
    sendGroup(`CG_J);
    sendGroup(`CG_K);
    rxExp = '{4'h5};
    for (int i = 0; i < n; i++) begin
      d = 4'(i + r);
      sendGroup(i == badPos ? badCg : ENC[d]);
      rxExp.push_back(d);
    end
    sendGroup(`CG_T);
    sendGroup(`CG_R);
    repeat (2) sendGroup(`CG_IDLE);
  endtask
  initial begin
    r = $urandom(32'h0a4c1c6e);
    repeat (8) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    r = $urandom;
    errAt = 5'($urandom_range(15));
    for (int i = 0; i < 16; i++) payload[4 * i +: 4] = 4'(i ^ r);
    for (int i = 0; i < 16; i++) txQ.push_back(i == errAt ? `CG_H : ENC[payload[4 * i +: 4]]);
    txQ.push_back(`CG_T);
    txQ.push_back(`CG_R);
    txQ.push_back(`CG_IDLE);
    go = 1'b1;
    fork
      begin
        @(posedge txEnable);
        @(posedge sys_clk);
        #1 go = 1'b0;
      end
      rxFrame(16, -1, 5'h00);
    join
    while (txQ.size() != 0) @(posedge sys_clk);
    check("rxCount", got.size(), rxExp.size());
    foreach (rxExp[i]) check("rxData", got[i], rxExp[i]);
    check("rxError", errSeen, 0);
    check("collision", colSeen, 1);
    foreach (BAD[k]) begin
      rxFrame(4, $urandom_range(3), BAD[k]);
      check("rxError", errSeen, 1);
      check("collision", colSeen, 0);
    end
    valSeen = 1'b0;
    foreach (ENC[k]) sendGroup(ENC[k]);
    check("rxValid", valSeen, 0);
    linkUp = 1'b0;
    go = 1'b1;
    @(posedge txEnable);
    @(posedge sys_clk);
    #1 go = 1'b0;
    @(negedge txEnable);
    repeat (60) @(posedge sys_clk);
    #1 check("carrier", carrierSense, 0);
    check("txIdle", txCodeBit, 1);
    linkUp = 1'b1;
    repeat (60) @(posedge sys_clk);
    give_verdict();
  end
endmodule
